// ==== design/timer_core_defs.vh ====
`ifndef TIMER_CORE_DEFS_VH
`define TIMER_CORE_DEFS_VH
// Word-index layout: bits [5:3] pick the channel, bits [2:0] the register
`define REG_CHANNEL_CONTROL   3'h0
`define REG_PIN_FUNCTION      3'h1
`define REG_CHANNEL_STATUS    3'h2
`define REG_CHANNEL_COUNT     3'h3
`define REG_COMPARE_CAPTURE_A 3'h4
`define REG_COMPARE_CAPTURE_B 3'h5
`define REG_STAGING_A         3'h6
`define REG_STAGING_B         3'h7
`define REG_FUNCTION_CONTROL  6'h28
// Reset values
`define COUNT_RESET           16'h0000
`define GENERAL_RESET         16'hffff
`define STAGING_RESET         16'hffff
`define CONTROL_RESET         7'h00
`define PIN_FUNCTION_RESET    8'h00
`define FUNCTION_RESET        16'h0000
`define ALL_ONES              16'hffff
// Channel control fields
`define CTRL_PRESCALE_LO      0
`define CTRL_EDGE_LO          3
`define CTRL_CLEAR_LO         5
// Clear select codes
`define CLEAR_NONE            2'h0
`define CLEAR_ON_A            2'h1
`define CLEAR_ON_B            2'h2
`define CLEAR_SYNC            2'h3
// Pin function: A in [2:0], B in [6:4]; bit 2 of a field picks capture
`define PIN_A_LO              0
`define PIN_B_LO              4
`define PIN_CAPTURE_BIT       2
// Status bits
`define STAT_FLAG_A           0
`define STAT_FLAG_B           1
`define STAT_WRAP             2
// Function control bits
`define FN_BUF_A3             0
`define FN_BUF_B3             1
`define FN_BUF_A4             2
`define FN_BUF_B4             3
`define FN_PHASE_CH2          4
`define FN_COMP_PWM           5
`define FN_RESET_SYNC_PWM     6
`define FN_PWM                7
`define FN_SYNC_LO            8
`endif

// ==== design/timer_counter_compare_capture_core.v ====
// Notes on behaviour
// - Five channels, each with 16-bit counter.
// - Counter advances on prescaler-selected clock pulses.
// - Channels 0 and 1 count upward only.
// - Channel 2 up/down in phase mode only.
// - Channels 3, 4 up/down in complementary PWM.
// - Selected compare match or capture clears counter.
// - Wrap from all ones sets wrap flag.
// - Down-count wrap from zero sets wrap flag.
// - Counter readable, writable by word or byte.
// - Counter zero after reset and in standby.
// - Pin control picks compare or capture per register.
// - Compare equality sets flag, may drive output.
// - Capture edge latches counter, sets flag together.
// - Pin control ignored in PWM mode; for channels 3, 4 also in complementary and reset-synchronized PWM.
// - General registers reset to compare, all ones.
// - General registers readable, writable word or byte.
// - Staging registers only in channels 3 and 4.
// - Four separate buffer enable bits in function control.
// - Compare match copies staging into general register.
// - Capture moves old general value into staging.
// - Staging registers all ones on reset, standby.
// - Staging registers readable, writable word or byte.
// - Clear select: none, A, B, synchronous.
// - Prescaler: clock divided 1/2/4/8, or external edges.
`include "timer_core_defs.vh"
module timer_counter_compare_capture_core (
  input  wire        clock_i,
  input  wire        reset_n_i,
  input  wire        ce_i,
  input  wire        standby_i,
  input  wire [5:0]  bus_addr_i,
  input  wire [15:0] bus_wdata_i,
  input  wire [1:0]  bus_be_i,
  input  wire        bus_wr_i,
  input  wire        bus_rd_i,
  output reg  [15:0] bus_rdata_o,
  input  wire [3:0]  ext_clk_i,
  input  wire [4:0]  capture_a_i,
  input  wire [4:0]  capture_b_i,
  output reg  [4:0]  compare_out_a_o,
  output reg  [4:0]  compare_out_b_o
);

  // Pick rising, falling or both edges: 00 rising, 01 falling, 1x both
  function edge_pick;
    input [1:0] sel;
    input       rise;
    input       fall;
    begin
      if (sel[1]) begin
        edge_pick = rise | fall;
      end else if (sel[0]) begin
        edge_pick = fall;
      end else begin
        edge_pick = rise;
      end
    end
  endfunction

  // Byte-lane merge of a bus write into a 16-bit register
  function [15:0] merge;
    input [15:0] old;
    input [15:0] wd;
    input [1:0]  be;
    begin
      merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    end
  endfunction

  reg [15:0] channel_count_r   [0:4];
  reg [15:0] compare_capture_a_r [0:4];
  reg [15:0] compare_capture_b_r [0:4];
  reg [15:0] staging_a_r       [3:4];
  reg [15:0] staging_b_r       [3:4];
  reg [6:0]  channel_control_r [0:4];
  reg [7:0]  pin_function_r    [0:4];
  reg [2:0]  channel_status_r  [0:4];
  reg [15:0] function_control_r;
  reg [2:0]  div_r;
  reg [1:0]  down_r;
  reg [3:0]  ext_s1_r;
  reg [3:0]  ext_s2_r;
  reg [3:0]  ext_s3_r;
  reg [9:0]  cap_s1_r;
  reg [9:0]  cap_s2_r;
  reg [9:0]  cap_s3_r;

  reg [4:0]  tick;
  reg [4:0]  up;
  reg [4:0]  ignore_pin;
  reg [4:0]  cap_mode_a;
  reg [4:0]  cap_mode_b;
  reg [4:0]  match_a;
  reg [4:0]  match_b;
  reg [4:0]  cap_a;
  reg [4:0]  cap_b;
  reg [4:0]  clear;
  reg [4:0]  buf_a;
  reg [4:0]  buf_b;
  reg        sync_clear;
  reg [15:0] rdata_nxt;
  reg [1:0]  psel;
  integer    k;
  integer    n;

  wire [3:0] ext_rise = ext_s2_r & ~ext_s3_r;
  wire [3:0] ext_fall = ~ext_s2_r & ext_s3_r;
  wire [9:0] cap_rise = cap_s2_r & ~cap_s3_r;
  wire [9:0] cap_fall = ~cap_s2_r & cap_s3_r;
  wire       reg_wr   = bus_wr_i & ce_i;

  // Event decode for every channel; purely from flops on this clock
  always @* begin
    buf_a = {function_control_r[`FN_BUF_A4], function_control_r[`FN_BUF_A3], 3'b000};
    buf_b = {function_control_r[`FN_BUF_B4], function_control_r[`FN_BUF_B3], 3'b000};
    sync_clear = 1'b0;
    // Own loop index: sharing one with the clocked process gives it two drivers
    for (n = 0; n < 5; n = n + 1) begin
      psel = channel_control_r[n][1:0];
      // Internal source ticks when the low divider bits are all ones
      if (!channel_control_r[n][2]) begin
        case (psel)
          2'h0:    tick[n] = 1'b1;
          2'h1:    tick[n] = div_r[0];
          2'h2:    tick[n] = &div_r[1:0];
          default: tick[n] = &div_r;
        endcase
      end else begin
        tick[n] = edge_pick(channel_control_r[n][4:3], ext_rise[psel], ext_fall[psel]);
      end
      up[n] = 1'b1;
      ignore_pin[n] = function_control_r[`FN_PWM];
      if (n == 2 && function_control_r[`FN_PHASE_CH2]) begin
        // Simplified phase input: clock A edges, clock B level gives direction
        tick[n] = ext_rise[0] | ext_fall[0];
        up[n]   = ~ext_s2_r[1];
      end
      if (n >= 3) begin
        if (function_control_r[`FN_COMP_PWM]) begin
          up[n] = ~down_r[n - 3];
        end
        if (function_control_r[`FN_COMP_PWM] | function_control_r[`FN_RESET_SYNC_PWM]) begin
          ignore_pin[n] = 1'b1;
        end
      end
      cap_mode_a[n] = pin_function_r[n][`PIN_A_LO + `PIN_CAPTURE_BIT] & ~ignore_pin[n];
      cap_mode_b[n] = pin_function_r[n][`PIN_B_LO + `PIN_CAPTURE_BIT] & ~ignore_pin[n];
      // Compare only at a count instant, so a parked counter matches once
      match_a[n] = ~cap_mode_a[n] & tick[n] & (channel_count_r[n] == compare_capture_a_r[n]);
      match_b[n] = ~cap_mode_b[n] & tick[n] & (channel_count_r[n] == compare_capture_b_r[n]);
      cap_a[n] = cap_mode_a[n] & edge_pick(pin_function_r[n][1:0], cap_rise[n], cap_fall[n]);
      cap_b[n] = cap_mode_b[n] & edge_pick(pin_function_r[n][5:4], cap_rise[n + 5],
                                           cap_fall[n + 5]);
      if (function_control_r[`FN_SYNC_LO + n]) begin
        case (channel_control_r[n][6:5])
          `CLEAR_ON_A: sync_clear = sync_clear | match_a[n] | cap_a[n];
          `CLEAR_ON_B: sync_clear = sync_clear | match_b[n] | cap_b[n];
          default:     sync_clear = sync_clear;
        endcase
      end
    end
    for (n = 0; n < 5; n = n + 1) begin
      case (channel_control_r[n][6:5])
        `CLEAR_ON_A: clear[n] = match_a[n] | cap_a[n];
        `CLEAR_ON_B: clear[n] = match_b[n] | cap_b[n];
        `CLEAR_SYNC: clear[n] = sync_clear & function_control_r[`FN_SYNC_LO + n];
        default:     clear[n] = 1'b0;
      endcase
    end
  end

  // Read mux; unmapped addresses read zero
  always @* begin
    rdata_nxt = 16'h0000;
    if (bus_addr_i == `REG_FUNCTION_CONTROL) begin
      rdata_nxt = function_control_r;
    end else if (bus_addr_i[5:3] < 3'h5) begin
      case (bus_addr_i[2:0])
        `REG_CHANNEL_CONTROL:   rdata_nxt = {8'h00, 1'b1, channel_control_r[bus_addr_i[5:3]]};
        `REG_PIN_FUNCTION:      rdata_nxt = {8'h00, pin_function_r[bus_addr_i[5:3]]};
        `REG_CHANNEL_STATUS:    rdata_nxt = {13'h0000, channel_status_r[bus_addr_i[5:3]]};
        `REG_CHANNEL_COUNT:     rdata_nxt = channel_count_r[bus_addr_i[5:3]];
        `REG_COMPARE_CAPTURE_A: rdata_nxt = compare_capture_a_r[bus_addr_i[5:3]];
        `REG_COMPARE_CAPTURE_B: rdata_nxt = compare_capture_b_r[bus_addr_i[5:3]];
        `REG_STAGING_A: begin
          if (bus_addr_i[5:3] == 3'h3) begin
            rdata_nxt = staging_a_r[3];
          end else if (bus_addr_i[5:3] == 3'h4) begin
            rdata_nxt = staging_a_r[4];
          end
        end
        default: begin
          if (bus_addr_i[5:3] == 3'h3) begin
            rdata_nxt = staging_b_r[3];
          end else if (bus_addr_i[5:3] == 3'h4) begin
            rdata_nxt = staging_b_r[4];
          end
        end
      endcase
    end
  end

  // Two-flop synchronisers plus one more stage for edge detection
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_s1_r <= 4'h0;
      ext_s2_r <= 4'h0;
      ext_s3_r <= 4'h0;
      cap_s1_r <= 10'h000;
      cap_s2_r <= 10'h000;
      cap_s3_r <= 10'h000;
      bus_rdata_o <= 16'h0000;
      div_r <= 3'h0;
    end else if (ce_i) begin
      ext_s1_r <= ext_clk_i;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
      cap_s1_r <= {capture_b_i, capture_a_i};
      cap_s2_r <= cap_s1_r;
      cap_s3_r <= cap_s2_r;
      div_r <= standby_i ? 3'h0 : div_r + 3'h1;
      if (bus_rd_i) begin
        bus_rdata_o <= rdata_nxt;
      end
    end
  end

  // Channel state; standby holds everything at reset values except the compare outputs, which keep their value
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (k = 0; k < 5; k = k + 1) begin
        channel_count_r[k] <= `COUNT_RESET;
        compare_capture_a_r[k] <= `GENERAL_RESET;
        compare_capture_b_r[k] <= `GENERAL_RESET;
        channel_control_r[k] <= `CONTROL_RESET;
        pin_function_r[k] <= `PIN_FUNCTION_RESET;
        channel_status_r[k] <= 3'h0;
      end
      for (k = 3; k < 5; k = k + 1) begin
        staging_a_r[k] <= `STAGING_RESET;
        staging_b_r[k] <= `STAGING_RESET;
      end
      function_control_r <= `FUNCTION_RESET;
      down_r <= 2'b00;
      compare_out_a_o <= 5'h00;
      compare_out_b_o <= 5'h00;
    end else if (ce_i) begin
      if (standby_i) begin
        for (k = 0; k < 5; k = k + 1) begin
          channel_count_r[k] <= `COUNT_RESET;
          compare_capture_a_r[k] <= `GENERAL_RESET;
          compare_capture_b_r[k] <= `GENERAL_RESET;
          channel_control_r[k] <= `CONTROL_RESET;
          pin_function_r[k] <= `PIN_FUNCTION_RESET;
          channel_status_r[k] <= 3'h0;
        end
        for (k = 3; k < 5; k = k + 1) begin
          staging_a_r[k] <= `STAGING_RESET;
          staging_b_r[k] <= `STAGING_RESET;
        end
        function_control_r <= `FUNCTION_RESET;
        down_r <= 2'b00;
      end else begin
        for (k = 0; k < 5; k = k + 1) begin
          // Counting; clear takes priority over the count step
          if (clear[k]) begin
            channel_count_r[k] <= `COUNT_RESET;
          end else if (tick[k]) begin
            channel_count_r[k] <= up[k] ? channel_count_r[k] + 16'h0001
                                        : channel_count_r[k] - 16'h0001;
          end
          // Status flags: hardware set beats a same-cycle software clear
          channel_status_r[k][`STAT_FLAG_A] <= (match_a[k] | cap_a[k]) |
            (channel_status_r[k][`STAT_FLAG_A] & ~(reg_wr & bus_be_i[0] &
             bus_addr_i == {k[2:0], `REG_CHANNEL_STATUS} & ~bus_wdata_i[`STAT_FLAG_A]));
          channel_status_r[k][`STAT_FLAG_B] <= (match_b[k] | cap_b[k]) |
            (channel_status_r[k][`STAT_FLAG_B] & ~(reg_wr & bus_be_i[0] &
             bus_addr_i == {k[2:0], `REG_CHANNEL_STATUS} & ~bus_wdata_i[`STAT_FLAG_B]));
          channel_status_r[k][`STAT_WRAP] <= (tick[k] & ~clear[k] &
            ((up[k] & channel_count_r[k] == `ALL_ONES) |
             (~up[k] & channel_count_r[k] == `COUNT_RESET))) |
            (channel_status_r[k][`STAT_WRAP] & ~(reg_wr & bus_be_i[0] &
             bus_addr_i == {k[2:0], `REG_CHANNEL_STATUS} & ~bus_wdata_i[`STAT_WRAP]));
          // Capture latches the count; compare match may reload from staging
          if (cap_a[k]) begin
            compare_capture_a_r[k] <= channel_count_r[k];
          end else if (k >= 3 && match_a[k] && buf_a[k]) begin
            compare_capture_a_r[k] <= staging_a_r[k];
          end
          if (cap_b[k]) begin
            compare_capture_b_r[k] <= channel_count_r[k];
          end else if (k >= 3 && match_b[k] && buf_b[k]) begin
            compare_capture_b_r[k] <= staging_b_r[k];
          end
          if (k >= 3) begin
            if (cap_a[k] & buf_a[k]) begin
              staging_a_r[k] <= compare_capture_a_r[k];
            end
            if (cap_b[k] & buf_b[k]) begin
              staging_b_r[k] <= compare_capture_b_r[k];
            end
          end
          // Output action on match: 01 low, 10 high, 11 toggle
          if (match_a[k] & ~ignore_pin[k]) begin
            case (pin_function_r[k][1:0])
              2'h1:    compare_out_a_o[k] <= 1'b0;
              2'h2:    compare_out_a_o[k] <= 1'b1;
              2'h3:    compare_out_a_o[k] <= ~compare_out_a_o[k];
              default: compare_out_a_o[k] <= compare_out_a_o[k];
            endcase
          end
          if (match_b[k] & ~ignore_pin[k]) begin
            case (pin_function_r[k][5:4])
              2'h1:    compare_out_b_o[k] <= 1'b0;
              2'h2:    compare_out_b_o[k] <= 1'b1;
              2'h3:    compare_out_b_o[k] <= ~compare_out_b_o[k];
              default: compare_out_b_o[k] <= compare_out_b_o[k];
            endcase
          end
          // Bus writes except status clears land last, so they win over same-cycle events
          if (reg_wr && bus_addr_i[5:3] == k[2:0]) begin
            case (bus_addr_i[2:0])
              `REG_CHANNEL_CONTROL: begin
                if (bus_be_i[0]) begin
                  channel_control_r[k] <= bus_wdata_i[6:0];
                end
              end
              `REG_PIN_FUNCTION: begin
                if (bus_be_i[0]) begin
                  pin_function_r[k] <= bus_wdata_i[7:0];
                end
              end
              `REG_CHANNEL_COUNT: channel_count_r[k] <= merge(channel_count_r[k],
                                    bus_wdata_i, bus_be_i);
              `REG_COMPARE_CAPTURE_A: compare_capture_a_r[k] <= merge(compare_capture_a_r[k],
                                        bus_wdata_i, bus_be_i);
              `REG_COMPARE_CAPTURE_B: compare_capture_b_r[k] <= merge(compare_capture_b_r[k],
                                        bus_wdata_i, bus_be_i);
              `REG_STAGING_A: begin
                if (k >= 3) begin
                  staging_a_r[k] <= merge(staging_a_r[k], bus_wdata_i, bus_be_i);
                end
              end
              `REG_STAGING_B: begin
                if (k >= 3) begin
                  staging_b_r[k] <= merge(staging_b_r[k], bus_wdata_i, bus_be_i);
                end
              end
              default: ;
            endcase
          end
        end
        // Triangle direction: turn down at match A, back up after underflow
        for (k = 3; k < 5; k = k + 1) begin
          if (!function_control_r[`FN_COMP_PWM]) begin
            down_r[k - 3] <= 1'b0;
          end else if (!down_r[k - 3] && match_a[k]) begin
            down_r[k - 3] <= 1'b1;
          end else if (down_r[k - 3] && tick[k] && channel_count_r[k] == `COUNT_RESET) begin
            down_r[k - 3] <= 1'b0;
          end
        end
        if (reg_wr && bus_addr_i == `REG_FUNCTION_CONTROL) begin
          function_control_r <= merge(function_control_r, bus_wdata_i, bus_be_i);
        end
      end
    end
  end

endmodule

// ==== tb/timer_core_asserts.sv ====
`include "timer_core_defs.vh"
module timer_core_asserts (
  input wire logic        clock_i,
  input wire logic        reset_n_i,
  input wire logic        ce_i,
  input wire logic        standby_i,
  input wire logic [5:0]  bus_addr_i,
  input wire logic [15:0] bus_wdata_i,
  input wire logic [1:0]  bus_be_i,
  input wire logic        bus_wr_i,
  input wire logic        bus_rd_i,
  input wire logic [15:0] bus_rdata_o,
  input wire logic [3:0]  ext_clk_i,
  input wire logic [4:0]  capture_a_i,
  input wire logic [4:0]  capture_b_i,
  input wire logic [4:0]  compare_out_a_o,
  input wire logic [4:0]  compare_out_b_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  // Decoded read request; reads are the only way rdata may move
  wire       rd_take = ce_i && bus_rd_i;
  wire [2:0] ch_sel  = bus_addr_i[5:3];
  wire [2:0] reg_sel = bus_addr_i[2:0];
  // Function control written, one quiet cycle, then read back
  sequence fc_write_read;
    ce_i && bus_wr_i && !standby_i && bus_addr_i == `REG_FUNCTION_CONTROL && bus_be_i == 2'h3
    ##1 !bus_wr_i && !standby_i
    ##1 rd_take && !standby_i && bus_addr_i == `REG_FUNCTION_CONTROL;
  endsequence
  // Two standby edges in a row with a read on the second
  sequence standby_read;
    standby_i && ce_i ##1 standby_i && rd_take && ch_sel < 3'h5;
  endsequence
  reset_out_a: assert property ($rose(reset_n_i) |-> bus_rdata_o == 16'h0000 && compare_out_a_o == 5'h00 && compare_out_b_o == 5'h00) else $error("outputs not zero after reset");
  rdata_hold_a: assert property (!rd_take |=> $stable(bus_rdata_o)) else $error("read data moved without read");
  ce_freeze_a: assert property (!ce_i |=> $stable(bus_rdata_o) && $stable(compare_out_a_o) && $stable(compare_out_b_o)) else $error("outputs moved with clock enable low");
  unmapped_zero_a: assert property (rd_take && bus_addr_i > `REG_FUNCTION_CONTROL |=> bus_rdata_o == 16'h0000) else $error("unmapped read not zero");
  staging_absent_a: assert property (rd_take && ch_sel < 3'h3 && reg_sel[2:1] == 2'h3 |=> bus_rdata_o == 16'h0000) else $error("staging read on channel without buffers");
  ctrl_bit7_a: assert property (rd_take && ch_sel < 3'h5 && reg_sel == `REG_CHANNEL_CONTROL |=> bus_rdata_o[7]) else $error("control bit 7 not one");
  fc_readback_a: assert property (fc_write_read |=> (bus_rdata_o & 16'h1fff) == ($past(bus_wdata_i, 3) & 16'h1fff)) else $error("function control readback wrong");
  standby_count_a: assert property (standby_read ##0 reg_sel == `REG_CHANNEL_COUNT |=> bus_rdata_o == `COUNT_RESET) else $error("count not cleared in standby");
  standby_general_a: assert property (standby_read ##0 reg_sel[2:1] == 2'h2 |=> bus_rdata_o == `GENERAL_RESET) else $error("general register not all ones in standby");
  standby_hold_a: assert property (standby_i && ce_i |=> $stable(compare_out_a_o) && $stable(compare_out_b_o)) else $error("compare output moved in standby");
endmodule
bind timer_counter_compare_capture_core timer_core_asserts u_asserts (
  .clock_i(clock_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .standby_i(standby_i),
  .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i), .bus_be_i(bus_be_i),
  .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .bus_rdata_o(bus_rdata_o), .ext_clk_i(ext_clk_i),
  .capture_a_i(capture_a_i), .capture_b_i(capture_b_i),
  .compare_out_a_o(compare_out_a_o), .compare_out_b_o(compare_out_b_o));

// ==== tb/cpu_bus_model.sv ====
module cpu_bus_model (
  input  wire logic        clock_i,
  output logic      [5:0]  bus_addr_o,
  output logic      [15:0] bus_wdata_o,
  output logic      [1:0]  bus_be_o,
  output logic             bus_wr_o,
  output logic             bus_rd_o,
  input  wire logic [15:0] bus_rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    bus_addr_o = 6'h00;
    bus_wdata_o = 16'h0000;
    bus_be_o = 2'h0;
    bus_wr_o = 1'b0;
    bus_rd_o = 1'b0;
  end
  // One write: held across the taking edge, released at the next falling edge
  task write_reg(input logic [5:0] a, input logic [15:0] d, input logic [1:0] b);
    @(negedge clock_i);
    bus_addr_o = a;
    bus_wdata_o = d;
    bus_be_o = b;
    bus_wr_o = 1'b1;
    @(negedge clock_i);
    bus_wr_o = 1'b0;
    bus_wdata_o = ~d; // Released data must not look valid
  endtask
  // One read: data is registered, so it is settled by the next falling edge
  task read_reg(input logic [5:0] a, output logic [15:0] d);
    @(negedge clock_i);
    bus_addr_o = a;
    bus_rd_o = 1'b1;
    @(negedge clock_i);
    bus_rd_o = 1'b0;
    d = bus_rdata_i;
  endtask
endmodule

// ==== tb/timer_counter_compare_capture_core_tb_top.sv ====
`include "timer_core_defs.vh"
module timer_counter_compare_capture_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [2:0] R_CTL = `REG_CHANNEL_CONTROL;
  localparam [2:0] R_PIN = `REG_PIN_FUNCTION;
  localparam [2:0] R_ST  = `REG_CHANNEL_STATUS;
  localparam [2:0] R_CNT = `REG_CHANNEL_COUNT;
  localparam [2:0] R_GA  = `REG_COMPARE_CAPTURE_A;
  localparam [2:0] R_GB  = `REG_COMPARE_CAPTURE_B;
  localparam [2:0] R_SA  = `REG_STAGING_A;
  localparam [2:0] R_SB  = `REG_STAGING_B;
  logic        clock_i, reset_n_i, ce_i, standby_i, bus_wr_i, bus_rd_i;
  logic [5:0]  bus_addr_i;
  logic [15:0] bus_wdata_i, bus_rdata_o, d0, d1;
  logic [1:0]  bus_be_i;
  logic [3:0]  ext_clk_i;
  logic [4:0]  capture_a_i, capture_b_i, compare_out_a_o, compare_out_b_o;
  int          n_errors, compares;
  timer_counter_compare_capture_core u_dut (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .ce_i(ce_i), .standby_i(standby_i), .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i),
    .bus_be_i(bus_be_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .bus_rdata_o(bus_rdata_o),
    .ext_clk_i(ext_clk_i), .capture_a_i(capture_a_i), .capture_b_i(capture_b_i),
    .compare_out_a_o(compare_out_a_o), .compare_out_b_o(compare_out_b_o));
  cpu_bus_model u_cpu (.clock_i(clock_i), .bus_addr_o(bus_addr_i), .bus_wdata_o(bus_wdata_i),
    .bus_be_o(bus_be_i), .bus_wr_o(bus_wr_i), .bus_rd_o(bus_rd_i), .bus_rdata_i(bus_rdata_o));
  // 50 MHz system clock
  always #10 clock_i = ~clock_i;
  function automatic logic [5:0] ad(input int c, input logic [2:0] r);
    ad = {c[2:0], r};
  endfunction
  task check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wr(input logic [5:0] a, input logic [15:0] d, input logic [1:0] b);
    u_cpu.write_reg(a, d, b);
  endtask
  task rchk(input logic [5:0] a, input logic [15:0] exp);
    logic [15:0] d;
    u_cpu.read_reg(a, d);
    check(d, exp);
  endtask
  task idle(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  // Rising then falling edge; sync plus edge detect needs three clocks
  task pulse_ext(input int i);
    ext_clk_i[i] = 1'b1;
    idle(5);
    ext_clk_i[i] = 1'b0;
    idle(5);
  endtask
  task conclude();
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Cut a hang short
  initial begin
    #2000000;
    n_errors++;
    conclude();
  end
  initial begin
    clock_i = 1'b0;
    reset_n_i = 1'b0;
    ce_i = 1'b1;
    standby_i = 1'b0;
    ext_clk_i = 4'h0;
    capture_a_i = 5'h00;
    capture_b_i = 5'h00;
    idle(5);
    reset_n_i = 1'b1;
    for (int c = 0; c < 5; c++) begin
      rchk(ad(c, R_GA), 16'hffff);
      rchk(ad(c, R_CTL), 16'h0080);
    end
    rchk(ad(3, R_SA), 16'hffff);
    rchk(ad(4, R_SB), 16'hffff);
    $display("test reset_values done");
    wr(ad(1, R_GA), 16'h1234, 2'h3);
    wr(ad(1, R_GA), 16'hab00, 2'h2);
    rchk(ad(1, R_GA), 16'hab34);
    wr(ad(3, R_SB), 16'h00cd, 2'h1);
    rchk(ad(3, R_SB), 16'hffcd);
    // Channel 0 on external A, so it only moves on our pulses
    wr(ad(0, R_CTL), 16'h0004, 2'h1);
    wr(ad(0, R_CNT), 16'h1234, 2'h3);
    rchk(ad(0, R_CNT), 16'h1234);
    wr(ad(0, R_CNT), 16'h00ff, 2'h1);
    wr(ad(0, R_CNT), 16'hff00, 2'h2);
    rchk(ad(0, R_CNT), 16'hffff);
    pulse_ext(0);
    rchk(ad(0, R_CNT), 16'h0000);
    rchk(ad(0, R_ST), 16'h0007);
    wr(ad(0, R_ST), 16'h0000, 2'h1);
    rchk(ad(0, R_ST), 16'h0000);
    wr(ad(0, R_CTL), 16'h0024, 2'h1);
    wr(ad(0, R_GA), 16'h0003, 2'h3);
    wr(ad(0, R_CNT), 16'h0002, 2'h3);
    pulse_ext(0);
    pulse_ext(0);
    rchk(ad(0, R_CNT), 16'h0000);
    rchk(ad(0, R_ST), 16'h0001);
    // Compare actions on count zero: A toggles, B drives high
    wr(ad(0, R_PIN), 16'h0023, 2'h1);
    wr(ad(0, R_GA), 16'h0000, 2'h3);
    wr(ad(0, R_GB), 16'h0000, 2'h3);
    pulse_ext(0);
    check({6'h00, compare_out_b_o, compare_out_a_o}, 16'h0021);
    pulse_ext(0);
    check({6'h00, compare_out_b_o, compare_out_a_o}, 16'h0020);
    $display("test count_compare done");
    for (int p = 0; p < 4; p++) begin
      wr(ad(1, R_CTL), p[15:0], 2'h1);
      u_cpu.read_reg(ad(1, R_CNT), d0);
      idle(14);
      u_cpu.read_reg(ad(1, R_CNT), d1);
      check(d1 - d0, 16'h0010 >> p);
    end
    wr(ad(1, R_CTL), 16'h0000, 2'h1);
    u_cpu.read_reg(ad(1, R_CNT), d0);
    ce_i = 1'b0;
    idle(10);
    ce_i = 1'b1;
    idle(4);
    u_cpu.read_reg(ad(1, R_CNT), d1);
    check(d1 - d0, 16'h0006);
    $display("test prescale done");
    // Capture on a frozen counter (external D never toggles)
    wr(ad(1, R_CTL), 16'h0007, 2'h1);
    wr(ad(1, R_PIN), 16'h0004, 2'h1);
    wr(ad(1, R_CNT), 16'h0777, 2'h3);
    capture_a_i[1] = 1'b1;
    idle(5);
    rchk(ad(1, R_GA), 16'h0777);
    rchk(ad(1, R_ST), 16'h0001);
    wr(6'h28, 16'h0001, 2'h3);
    wr(ad(3, R_CTL), 16'h0007, 2'h1);
    wr(ad(3, R_PIN), 16'h0004, 2'h1);
    wr(ad(3, R_GA), 16'h1111, 2'h3);
    wr(ad(3, R_CNT), 16'h2222, 2'h3);
    capture_a_i[3] = 1'b1;
    idle(5);
    rchk(ad(3, R_GA), 16'h2222);
    rchk(ad(3, R_SA), 16'h1111);
    wr(6'h28, 16'h0004, 2'h3);
    wr(ad(4, R_CTL), 16'h0004, 2'h1);
    wr(ad(4, R_GA), 16'h0005, 2'h3);
    wr(ad(4, R_CNT), 16'h0005, 2'h3);
    wr(ad(4, R_SA), 16'h0042, 2'h3);
    pulse_ext(0);
    rchk(ad(4, R_GA), 16'h0042);
    rchk(ad(4, R_CNT), 16'h0006);
    // Complementary PWM: match A turns channel 4 downward
    wr(6'h28, 16'h0020, 2'h3);
    wr(ad(4, R_GA), 16'h0007, 2'h3);
    wr(ad(4, R_CNT), 16'h0007, 2'h3);
    pulse_ext(0);
    pulse_ext(0);
    rchk(ad(4, R_CNT), 16'h0007);
    $display("test capture_buffer done");
    // Phase mode: external B high means count down
    wr(6'h28, 16'h0010, 2'h3);
    rchk(6'h28, 16'h0010);
    wr(ad(2, R_CNT), 16'h0000, 2'h3);
    ext_clk_i[1] = 1'b1;
    ext_clk_i[0] = 1'b1;
    idle(5);
    rchk(ad(2, R_CNT), 16'hffff);
    rchk(ad(2, R_ST), 16'h0004);
    ext_clk_i = 4'h0;
    wr(ad(0, R_SA), 16'h5555, 2'h3);
    rchk(ad(0, R_SA), 16'h0000);
    rchk(6'h30, 16'h0000);
    $display("test phase_map done");
    standby_i = 1'b1;
    rchk(ad(0, R_CNT), 16'h0000);
    rchk(ad(1, R_GA), 16'hffff);
    rchk(ad(3, R_SA), 16'hffff);
    wr(ad(1, R_GA), 16'h0001, 2'h3);
    standby_i = 1'b0;
    rchk(ad(1, R_GA), 16'hffff);
    rchk(6'h28, 16'h0000);
    // Channel 2 now counts every clock; the write must win over that tick
    wr(ad(2, R_CNT), 16'h4000, 2'h3);
    rchk(ad(2, R_CNT), 16'h4001);
    $display("test standby done");
    conclude();
  end
endmodule
